// File: ddct_defs.svh
// Register offsets, command bit positions and reset values of the dual down-counter timer.
// Assumes a byte-wide register port decoded on a 4-bit offset.
`ifndef DDCT_DEFS_SVH
`define DDCT_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DDCT_ADDR_W 4
`define DDCT_OFS_LOW 4'hc
`define DDCT_OFS_MID 4'hd
`define DDCT_OFS_HIGH 4'he
`define DDCT_OFS_CMD 4'hf

// ****************************************
// Command bit positions
// ****************************************
`define DDCT_CMD_SEL 7
`define DDCT_CMD_LATCH 6
`define DDCT_CMD_GATE_OFF 5
`define DDCT_CMD_GATE_ON 4
`define DDCT_CMD_COUNT_OFF 3
`define DDCT_CMD_COUNT_ON 2
`define DDCT_CMD_LOAD 1
`define DDCT_CMD_ZERO 0

// ****************************************
// Widths and reset values
// ****************************************
`define DDCT_W0 24
`define DDCT_W1 16
`define DDCT_BYTE_RST 8'h00
// Arbitrary neutral revision code
`define DDCT_REVISION 8'h11

`endif

// File: ddct_pkg.sv
// Types shared by the dual down-counter timer files.
// Assumes ddct_defs.svh is compiled alongside.
package ddct_pkg;
  typedef logic [7:0] ddct_byte_t;
endpackage

// File: ddct_counter.sv
// One down-counter with load, clear, gating and count enable.
// Assumes pulse and gate are already synchronised to clk_i.
`include "ddct_defs.svh"

module ddct_counter #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic pulse_rise_i,
  input wire logic gate_i,
  input wire logic gate_on_i,
  input wire logic gate_off_i,
  input wire logic count_on_i,
  input wire logic count_off_i,
  input wire logic load_i,
  input wire logic zero_i,
  input wire logic [W-1:0] load_val_i,
  output logic [W-1:0] value_o
);

  logic [W-1:0] cnt_q;
  logic gate_en_q;
  logic count_en_q;

  // Decrement needs count enable and, if gated, a high gate
  wire logic step = pulse_rise_i && count_en_q && (!gate_en_q || gate_i);

  // Mode flags, each command touches only its own flag
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_en_q <= 1'b0;
      count_en_q <= 1'b0;
    end else if (ce_i) begin
      if (gate_on_i) gate_en_q <= 1'b1;
      else if (gate_off_i) gate_en_q <= 1'b0;
      if (count_on_i) count_en_q <= 1'b1;
      else if (count_off_i) count_en_q <= 1'b0;
    end
  end

  // Load and clear win over a coincident decrement
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (zero_i) cnt_q <= '0;
      else if (load_i) cnt_q <= load_val_i;
      else if (step) cnt_q <= cnt_q - W'(1);
    end
  end

  assign value_o = cnt_q;

  // ****************************************
  // Checks
  // ****************************************
  zero_clears_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && zero_i |=> cnt_q == '0)
    else $error("clear did not zero counter");
  load_wins_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && load_i && !zero_i |=> cnt_q == $past(load_val_i))
    else $error("load value not taken");
  gate_holds_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && gate_en_q && !gate_i && !load_i && !zero_i |=> $stable(cnt_q))
    else $error("counted with gate low");
  hold_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !count_en_q && !load_i && !zero_i |=> $stable(cnt_q))
    else $error("counted while disabled");
  step_one_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && step && !load_i && !zero_i |=> cnt_q == $past(cnt_q) - W'(1))
    else $error("decrement not one");
  gate_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && gate_off_i && !gate_on_i |=> !gate_en_q)
    else $error("gating not off");

endmodule

// File: ddct_timer.sv
// Dual down-counter timer: 24-bit and 16-bit counters behind four byte registers.
// Assumes a same-clock byte register port; pulse and gate pins are asynchronous.
`include "ddct_defs.svh"

module ddct_timer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [`DDCT_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic count_pulse_first_i,
  input wire logic count_pulse_second_i,
  input wire logic gate_input_first_i,
  input wire logic gate_input_second_i,
  output logic [7:0] rdata_o,
  output logic [`DDCT_W0-1:0] count_first_o,
  output logic [`DDCT_W1-1:0] count_second_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_s2_q;

  // Release through two flops so no flop sees a ragged release edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire logic rst_b = rst_s2_q;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [1:0] pulse_old_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pulse_old_q <= 2'h0;
    end else if (ce_i) begin
      pin_s1_q <= {gate_input_second_i, gate_input_first_i,
                   count_pulse_second_i, count_pulse_first_i};
      pin_s2_q <= pin_s1_q;
      pulse_old_q <= pin_s2_q[1:0];
    end
  end

  // One step per synchronised rising edge
  wire logic [1:0] pulse_rise = pin_s2_q[1:0] & ~pulse_old_q;

  // ****************************************
  // Register decode
  // ****************************************
  wire logic sel_low = addr_i == `DDCT_OFS_LOW;
  wire logic sel_mid = addr_i == `DDCT_OFS_MID;
  wire logic sel_high = addr_i == `DDCT_OFS_HIGH;
  wire logic sel_cmd = addr_i == `DDCT_OFS_CMD;
  wire logic cmd_wr = ce_i && wr_i && sel_cmd;

  // Command fields, counter select then one-hot operation
  wire logic cmd_ctr1 = wdata_i[`DDCT_CMD_SEL];
  wire logic [1:0] cmd_hit = cmd_wr ? {cmd_ctr1, !cmd_ctr1} : 2'b00;
  wire logic latch_cmd = cmd_wr && wdata_i[`DDCT_CMD_LATCH];

  // Counter 0 strobes; in one write gate on beats gate off, count on beats count off, clear beats load
  wire logic ctr0_gate_on = cmd_hit[0] && wdata_i[`DDCT_CMD_GATE_ON];
  wire logic ctr0_gate_off = cmd_hit[0] && wdata_i[`DDCT_CMD_GATE_OFF];
  wire logic ctr0_count_on = cmd_hit[0] && wdata_i[`DDCT_CMD_COUNT_ON];
  wire logic ctr0_count_off = cmd_hit[0] && wdata_i[`DDCT_CMD_COUNT_OFF];
  wire logic ctr0_load = cmd_hit[0] && wdata_i[`DDCT_CMD_LOAD];
  wire logic ctr0_zero = cmd_hit[0] && wdata_i[`DDCT_CMD_ZERO];

  // Counter 1 strobes; its load path never sees the high holding byte
  wire logic ctr1_gate_on = cmd_hit[1] && wdata_i[`DDCT_CMD_GATE_ON];
  wire logic ctr1_gate_off = cmd_hit[1] && wdata_i[`DDCT_CMD_GATE_OFF];
  wire logic ctr1_count_on = cmd_hit[1] && wdata_i[`DDCT_CMD_COUNT_ON];
  wire logic ctr1_count_off = cmd_hit[1] && wdata_i[`DDCT_CMD_COUNT_OFF];
  wire logic ctr1_load = cmd_hit[1] && wdata_i[`DDCT_CMD_LOAD];
  wire logic ctr1_zero = cmd_hit[1] && wdata_i[`DDCT_CMD_ZERO];

  // ****************************************
  // Holding and snapshot bytes
  // ****************************************
  ddct_pkg::ddct_byte_t hold_low_q;
  ddct_pkg::ddct_byte_t hold_mid_q;
  ddct_pkg::ddct_byte_t hold_high_q;
  ddct_pkg::ddct_byte_t snap_low_q;
  ddct_pkg::ddct_byte_t snap_mid_q;
  ddct_pkg::ddct_byte_t snap_high_q;
  logic [`DDCT_W0-1:0] val0;
  logic [`DDCT_W1-1:0] val1;

  // Writes land in holding bytes; counters take them only on a load command
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      hold_low_q <= `DDCT_BYTE_RST;
      hold_mid_q <= `DDCT_BYTE_RST;
      hold_high_q <= `DDCT_BYTE_RST;
    end else if (ce_i && wr_i) begin
      if (sel_low) hold_low_q <= wdata_i;
      if (sel_mid) hold_mid_q <= wdata_i;
      if (sel_high) hold_high_q <= wdata_i;
    end
  end

  // Latched byte source per selected counter
  wire ddct_pkg::ddct_byte_t lat_low = cmd_ctr1 ? val1[7:0] : val0[7:0];
  wire ddct_pkg::ddct_byte_t lat_mid = cmd_ctr1 ? val1[15:8] : val0[15:8];

  // Counter 1 latch leaves the high snapshot byte alone
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      snap_low_q <= `DDCT_BYTE_RST;
      snap_mid_q <= `DDCT_BYTE_RST;
      snap_high_q <= `DDCT_BYTE_RST;
    end else if (latch_cmd) begin
      snap_low_q <= lat_low;
      snap_mid_q <= lat_mid;
      if (!cmd_ctr1) snap_high_q <= val0[23:16];
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  wire logic [`DDCT_W0-1:0] load0 = {hold_high_q, hold_mid_q, hold_low_q};
  wire logic [`DDCT_W1-1:0] load1 = {hold_mid_q, hold_low_q};

  ddct_counter #(.W(`DDCT_W0)) u_ctr0 (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .ce_i(ce_i),
    .pulse_rise_i(pulse_rise[0]),
    .gate_i(pin_s2_q[2]),
    .gate_on_i(ctr0_gate_on),
    .gate_off_i(ctr0_gate_off),
    .count_on_i(ctr0_count_on),
    .count_off_i(ctr0_count_off),
    .load_i(ctr0_load),
    .zero_i(ctr0_zero),
    .load_val_i(load0),
    .value_o(val0)
  );

  ddct_counter #(.W(`DDCT_W1)) u_ctr1 (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .ce_i(ce_i),
    .pulse_rise_i(pulse_rise[1]),
    .gate_i(pin_s2_q[3]),
    .gate_on_i(ctr1_gate_on),
    .gate_off_i(ctr1_gate_off),
    .count_on_i(ctr1_count_on),
    .count_off_i(ctr1_count_off),
    .load_i(ctr1_load),
    .zero_i(ctr1_zero),
    .load_val_i(load1),
    .value_o(val1)
  );

  // ****************************************
  // Read port
  // ****************************************
  // Data reads come from snapshots, never holding bytes
  wire ddct_pkg::ddct_byte_t rd_mux =
    sel_low ? snap_low_q :
    sel_mid ? snap_mid_q :
    sel_high ? snap_high_q :
    sel_cmd ? `DDCT_REVISION : 8'h00;

  // Read data stands for one enabled cycle per read strobe, zero in other enabled cycles; enable low holds it
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rdata_o <= 8'h00;
      count_first_o <= '0;
      count_second_o <= '0;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      count_first_o <= val0;
      count_second_o <= val1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Register port: revision, snapshots, one-cycle read data
  rev_read_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && rd_i && sel_cmd |=> rdata_o == `DDCT_REVISION)
    else $error("revision not returned");

  snap_read_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && rd_i && sel_low && !latch_cmd |=> rdata_o == snap_low_q)
    else $error("low read not snapshot");

  // A stale byte left on the port would look like a second read
  idle_read_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data outstayed its cycle");

  unmapped_read_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && rd_i && !(sel_low || sel_mid || sel_high || sel_cmd) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // Holding bytes take every data write
  hold_low_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && wr_i && sel_low |=> hold_low_q == $past(wdata_i))
    else $error("low holding byte missed write");

  hold_mid_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && wr_i && sel_mid |=> hold_mid_q == $past(wdata_i))
    else $error("mid holding byte missed write");

  hold_high_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && wr_i && sel_high |=> hold_high_q == $past(wdata_i))
    else $error("high holding byte missed write");

  // Snapshots per counter select
  high_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    latch_cmd && cmd_ctr1 |=> $stable(snap_high_q))
    else $error("high snapshot disturbed");

  latch_low_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    latch_cmd && !cmd_ctr1 |=> snap_low_q == $past(val0[7:0]))
    else $error("low snapshot wrong");

  latch_low_one_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    latch_cmd && cmd_ctr1 |=> snap_low_q == $past(val1[7:0]))
    else $error("counter 1 low snapshot wrong");

  latch_mid_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    latch_cmd && cmd_ctr1 |=> snap_mid_q == $past(val1[15:8]))
    else $error("mid snapshot wrong");

  latch_mid_first_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    latch_cmd && !cmd_ctr1 |=> snap_mid_q == $past(val0[15:8]))
    else $error("counter 0 mid snapshot wrong");

  latch_high_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    latch_cmd && !cmd_ctr1 |=> snap_high_q == $past(val0[23:16]))
    else $error("high snapshot wrong");

  // Counters move only on commands and pulses
  write_only_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i && wr_i && !sel_cmd && pulse_rise == 2'b00 |=> $stable(val0) && $stable(val1))
    else $error("data write moved counter");

  load1_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ctr1_load && !ctr1_zero |=> val1 == $past(load1))
    else $error("counter 1 load wrong");

  load0_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ctr0_load && !ctr0_zero |=> val0 == $past(load0))
    else $error("counter 0 load wrong");

  // Output copies trail the counters by exactly one cycle
  out_track_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    ce_i |=> count_first_o == $past(val0)
      && count_second_o == $past(val1))
    else $error("count outputs not one cycle behind");

  // Enable low must hold the outputs, both counters and the low holding and snapshot bytes
  freeze_all_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    !ce_i |=> $stable(rdata_o) && $stable(count_first_o) && $stable(count_second_o)
      && $stable(val0) && $stable(val1) && $stable(hold_low_q) && $stable(snap_low_q))
    else $error("state moved with enable low");

endmodule

// File: ddct_timer_tb.sv
// Self-checking bench for the dual down-counter timer, driving its register port and pins.
// Assumes the design files and ddct_defs.svh are compiled before this file.
`include "ddct_defs.svh"

module ddct_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Stimulus signals and counters
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [`DDCT_ADDR_W-1:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic count_pulse_first_i = 1'b0;
  logic count_pulse_second_i = 1'b0;
  logic gate_input_first_i = 1'b0;
  logic gate_input_second_i = 1'b0;
  logic [7:0] rdata_o;
  logic [`DDCT_W0-1:0] count_first_o;
  logic [`DDCT_W1-1:0] count_second_o;
  int fails = 0;
  int comparisons = 0;

  ddct_timer dut (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .count_pulse_first_i(count_pulse_first_i),
    .count_pulse_second_i(count_pulse_second_i),
    .gate_input_first_i(gate_input_first_i),
    .gate_input_second_i(gate_input_second_i),
    .rdata_o(rdata_o),
    .count_first_o(count_first_o),
    .count_second_o(count_second_o)
  );

  // 25 ns period clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe dropped with an idle edge after, so a following call never rewrites it same step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Read data stands only in the cycle after the strobe, so sample it mid-cycle there
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check({16'h0000, rdata_o}, {16'h0000, e});
    @(posedge clk_i);
  endtask

  task automatic cnt(input logic [23:0] e0, input logic [15:0] e1);
    @(negedge clk_i);
    check(count_first_o, e0);
    check({8'h00, count_second_o}, {8'h00, e1});
    @(posedge clk_i);
  endtask

  // Pin held high for three cycles and low for six, longer than the two-flop sync needs
  task automatic pulse(input logic sel);
    if (sel) count_pulse_second_i <= 1'b1;
    else count_pulse_first_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    count_pulse_first_i <= 1'b0;
    count_pulse_second_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // Command strobe lands on the edge where the synchronised rise would decrement
  task automatic coincide(input logic sel, input logic [7:0] cmd);
    if (sel) count_pulse_second_i <= 1'b1;
    else count_pulse_first_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    wr(`DDCT_OFS_CMD, cmd);
    count_pulse_first_i <= 1'b0;
    count_pulse_second_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    cnt(24'h000000, 16'h0000);
    rd(`DDCT_OFS_LOW, `DDCT_BYTE_RST);
    rd(`DDCT_OFS_MID, `DDCT_BYTE_RST);
    rd(`DDCT_OFS_HIGH, `DDCT_BYTE_RST);
    rd(`DDCT_OFS_CMD, `DDCT_REVISION);
    rd(4'h0, 8'h00);
    // Offsets are the page-0 ones; page selection sits upstream of this port
    wr(`DDCT_OFS_LOW, 8'h56);
    wr(`DDCT_OFS_MID, 8'h34);
    wr(`DDCT_OFS_HIGH, 8'h12);
    rd(`DDCT_OFS_LOW, 8'h00);
    cnt(24'h000000, 16'h0000);
    wr(`DDCT_OFS_CMD, 8'h02);
    cnt(24'h123456, 16'h0000);
    wr(`DDCT_OFS_CMD, 8'h40);
    rd(`DDCT_OFS_LOW, 8'h56);
    rd(`DDCT_OFS_MID, 8'h34);
    rd(`DDCT_OFS_HIGH, 8'h12);
    wr(`DDCT_OFS_LOW, 8'h78);
    wr(`DDCT_OFS_MID, 8'h9a);
    wr(`DDCT_OFS_CMD, 8'h82);
    cnt(24'h123456, 16'h9a78);
    wr(`DDCT_OFS_CMD, 8'hc0);
    rd(`DDCT_OFS_LOW, 8'h78);
    rd(`DDCT_OFS_MID, 8'h9a);
    rd(`DDCT_OFS_HIGH, 8'h12);
    // Counting starts disabled, so a pulse must not move the value
    pulse(1'b0);
    cnt(24'h123456, 16'h9a78);
    wr(`DDCT_OFS_CMD, 8'h04);
    pulse(1'b0);
    pulse(1'b0);
    cnt(24'h123454, 16'h9a78);
    wr(`DDCT_OFS_CMD, 8'h84);
    pulse(1'b1);
    cnt(24'h123454, 16'h9a77);
    wr(`DDCT_OFS_CMD, 8'h08);
    pulse(1'b0);
    cnt(24'h123454, 16'h9a77);
    wr(`DDCT_OFS_CMD, 8'h04);
    wr(`DDCT_OFS_CMD, 8'h10);
    pulse(1'b0);
    cnt(24'h123454, 16'h9a77);
    gate_input_first_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    pulse(1'b0);
    cnt(24'h123453, 16'h9a77);
    wr(`DDCT_OFS_CMD, 8'h20);
    gate_input_first_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    pulse(1'b0);
    cnt(24'h123452, 16'h9a77);
    wr(`DDCT_OFS_CMD, 8'h01);
    cnt(24'h000000, 16'h9a77);
    pulse(1'b0);
    cnt(24'hffffff, 16'h9a77);
    wr(`DDCT_OFS_CMD, 8'h90);
    pulse(1'b1);
    cnt(24'hffffff, 16'h9a77);
    gate_input_second_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    pulse(1'b1);
    cnt(24'hffffff, 16'h9a76);
    wr(`DDCT_OFS_CMD, 8'ha0);
    gate_input_second_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    pulse(1'b1);
    cnt(24'hffffff, 16'h9a75);
    // Enable low: a clear and a pulse must both be lost
    ce_i <= 1'b0;
    wr(`DDCT_OFS_CMD, 8'h81);
    pulse(1'b1);
    ce_i <= 1'b1;
    cnt(24'hffffff, 16'h9a75);
    wr(`DDCT_OFS_LOW, 8'h10);
    wr(`DDCT_OFS_MID, 8'h00);
    wr(`DDCT_OFS_HIGH, 8'h00);
    coincide(1'b0, 8'h02);
    cnt(24'h000010, 16'h9a75);
    coincide(1'b1, 8'h81);
    cnt(24'h000010, 16'h0000);
    conclude();
  end

  // Whole run is a few hundred cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    conclude();
  end
endmodule
